// ---- common/fhrp_pkg.sv ----
// Constants shared by the host register port of the line framer.
// Assumes one clock: the receive line clock drives every register.
package fhrp_pkg;

  // ---------------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int BUF_AW   = 3;                // Eight message bytes
  localparam int CTRL_NUM = 6;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] LINE_MODE_AND_LOOPBACK_CONTROL_OFS = 8'h00;
  localparam logic [7:0] DATA_LINK_TRANSMIT_CONTROL_OFS     = 8'h01;
  localparam logic [7:0] INTERRUPT_ENABLE_CONTROL_OFS       = 8'h02;
  localparam logic [7:0] FAR_END_ALARM_TRANSMIT_CODE_OFS    = 8'h03;
  localparam logic [7:0] FEATURE_CONTROL_OFS                = 8'h04;
  localparam logic [7:0] HDLC_AND_PARALLEL_PORT_CONTROL_OFS = 8'h05;
  localparam logic [7:0] RECEIVE_ALARM_STATUS_OFS           = 8'h10;
  localparam logic [7:0] COUNTER_INTERRUPT_STATUS_OFS       = 8'h11;
  localparam logic [7:0] DATA_LINK_INTERRUPT_STATUS_OFS     = 8'h12;
  localparam logic [7:0] FAR_END_ALARM_RECEIVE_CODE_OFS     = 8'h13;
  localparam logic [7:0] DATA_LINK_RECEIVE_STATUS_OFS       = 8'h14;
  localparam logic [7:0] PART_AND_VERSION_ID_OFS            = 8'h15;
  localparam logic [7:0] LATCHED_ALARM_SHADOW_OFS           = 8'h16;
  localparam logic [7:0] PARITY_ERROR_COUNT_OFS             = 8'h20;
  localparam logic [7:0] DISAGREEMENT_COUNTS_OFS            = 8'h21;
  localparam logic [7:0] FRAME_ERROR_COUNT_OFS              = 8'h22;
  localparam logic [7:0] PATH_PARITY_ERROR_COUNT_OFS        = 8'h23;
  localparam logic [7:0] FAR_END_BLOCK_ERROR_COUNT_OFS      = 8'h24;
  localparam logic [7:0] CODE_VIOLATION_COUNT_LOW_OFS       = 8'h25;
  localparam logic [7:0] CODE_VIOLATION_COUNT_HIGH_OFS      = 8'h26;
  localparam logic [7:0] TRANSMIT_LINK_MESSAGE_BUFFER_OFS   = 8'h30;
  localparam logic [7:0] RECEIVE_LINK_MESSAGE_BUFFER_OFS    = 8'h40;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  // Interrupt enable control and counter interrupt status share these
  localparam int PAR_BIT  = 0;
  localparam int DGR_BIT  = 1;
  localparam int FERR_BIT = 2;
  localparam int PTH_BIT  = 3;
  localparam int FEBE_BIT = 4;
  localparam int LCV_BIT  = 5;
  localparam int SHDW_BIT = 6;
  // Feature control: disable saturation of code violation / frame errors
  localparam int DIS_SAT_BIT = 4;
  // Data link interrupt status keeps only its low nibble
  localparam logic [7:0] DL_INT_MASK   = 8'h0f;
  localparam logic [7:0] DL_RX_MASK    = 8'h3f;
  localparam logic [7:0] SHADOW_MASK   = 8'h3f;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ---------------------------------------------------------------------
  // Timing in receive clock periods
  // ---------------------------------------------------------------------
  localparam int RD_MIN_PERIODS  = 3;        // Least read strobe width
  localparam int RD_GAP_PERIODS  = 3;        // Least gap between reads

endpackage

// ---- hdl/fhrp_err_counter.sv ----
// One error counter with per-bit clear-on-read and saturate or wrap.
// Assumes increments and clears come from logic on the same clock.
`timescale 1ns/10ps
module fhrp_err_counter #(
  parameter int W = 8
) (
  input  wire logic         clk_i,   // Receive line clock
  input  wire logic         rst_n_i, // Asynchronous reset, active low
  input  wire logic         inc_i,   // One error this cycle
  input  wire logic [W-1:0] clr_i,   // Bits cleared by a host read
  input  wire logic         roll_i,  // Wrap at top instead of saturate
  output logic      [W-1:0] cnt_o,   // Current count
  output logic              top_o    // Pulse: an error arrived while already at top
);
  import fhrp_pkg::*;

  logic [W-1:0] kept;
  logic         at_top;

  // ---------------------------------------------------------------------
  // Count
  // ---------------------------------------------------------------------
  // Clear and increment land in one cycle, so an error during a read
  // is counted once, in the fresh count, and never lost
  assign kept   = cnt_o & ~clr_i;
  assign at_top = &kept;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_o <= '0;
    else if (inc_i && !(at_top && !roll_i))
      cnt_o <= W'(kept + 1'b1);
    else
      cnt_o <= kept;
  end

  // Top event on overflow attempt, raises the counter interrupt flag
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      top_o <= 1'b0;
    else
      top_o <= inc_i && at_top;
  end

endmodule

// ---- hdl/fhrp_host_port.sv ----
// Host register port of the line framer: multiplexed address/data bus,
// control, status, counters and the two link message buffers.
// Assumes CLK_I is the receive line clock and the event inputs come
// from framing logic on that clock; host pins are asynchronous.
//
// Overview of operation
// - Read circuit runs on the receive line clock.
// - Address is set up around latch strobe fall; port captures it there.
// - Write data is stable around write strobe rise; taken at that rise.
// - Eight read/write transmit message bytes at 0x30 to 0x37.
// - Eight receive message bytes at 0x40 to 0x47 for the host.
// - Status and counters at 0x10-0x16, 0x20-0x26 ignore writes.
// - Reading a counter zeroes it and clears its interrupt flag.
// - Errors during a counter read are neither lost nor doubled.
// - Reading the disagreement address clears both nibbles.
`timescale 1ns/10ps
module fhrp_host_port #(
  parameter logic [7:0] PART_VERSION = 8'h5a  // Arbitrary identity value
) (
  input  wire logic                     CLK_I,           // Receive clock
  input  wire logic                     RESET_N_I,       // Async reset
  input  wire logic                     ALE_I,           // Address latch
  input  wire logic                     CS_N_I,          // Chip select
  input  wire logic                     RD_N_I,          // Read strobe
  input  wire logic                     WR_N_I,          // Write strobe
  input  wire logic [fhrp_pkg::DATA_W-1:0] AD_I,         // Bus in
  output logic      [fhrp_pkg::DATA_W-1:0] AD_O,         // Bus out
  output logic                          AD_OE_O,         // Bus drive
  output logic      [7:0]               LINE_MODE_O,     // Control 0x00
  output logic      [7:0]               DL_TX_CTRL_O,    // Control 0x01
  output logic      [7:0]               INT_EN_O,        // Control 0x02
  output logic      [7:0]               FEAC_TX_O,       // Control 0x03
  output logic      [7:0]               FEATURE_O,       // Control 0x04
  output logic      [7:0]               HDLC_CTRL_O,     // Control 0x05
  input  wire logic [7:0]               ALARM_STATUS_I,  // Live alarms
  input  wire logic [7:0]               DL_INT_I,        // Link events
  input  wire logic [7:0]               FEAC_RX_I,       // Far-end code
  input  wire logic [7:0]               DL_RX_STATUS_I,  // Link status
  input  wire logic [7:0]               SHADOW_I,        // Latched alarms
  input  wire logic                     SHADOW_INT_I,    // Shadow event
  input  wire logic                     PAR_ERR_I,       // Parity error
  input  wire logic                     PAR_DGR_I,       // P-bit mismatch
  input  wire logic                     X_DGR_I,         // X-bit mismatch
  input  wire logic                     FRM_ERR_I,       // Framing error
  input  wire logic                     PTH_ERR_I,       // Path parity err
  input  wire logic                     FEBE_I,          // Far-end block
  input  wire logic                     LCV_I,           // Code violation
  input  wire logic [fhrp_pkg::BUF_AW-1:0] TX_BUF_ADDR_I, // Link tx index
  output logic      [7:0]               TX_BUF_DATA_O,   // Link tx byte
  input  wire logic                     RX_BUF_WE_I,     // Link rx write
  input  wire logic [fhrp_pkg::BUF_AW-1:0] RX_BUF_ADDR_I, // Link rx index
  input  wire logic [7:0]               RX_BUF_DATA_I,   // Link rx byte
  output logic      [7:0]               CNT_INT_O        // Counter flags
);
  import fhrp_pkg::*;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [3:0]        ctl_s1_q, ctl_s2_q, ctl_s3_q;  // ALE inverted, CS_N, RD_N, WR_N
  logic [DATA_W-1:0] ad_s1_q, ad_s2_q;
  logic              ale_fall, rd_fall, wr_rise, rd_high;

  // Bus pins are async to the receive clock; data is delayed the same
  // two stages so it stays aligned with the strobe edges
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ctl_s1_q <= 4'hf;
      ctl_s2_q <= 4'hf;
      ctl_s3_q <= 4'hf;
      ad_s1_q  <= BYTE_RST;
      ad_s2_q  <= BYTE_RST;
    end
    else
    begin
      ctl_s1_q <= {~ALE_I, CS_N_I, RD_N_I, WR_N_I};
      ctl_s2_q <= ctl_s1_q;
      ctl_s3_q <= ctl_s2_q;
      ad_s1_q  <= AD_I;
      ad_s2_q  <= ad_s1_q;
    end
  end

  // Edges seen after synchronising; a read strobe shorter than one
  // clock period could fall between samples and be missed
  assign ale_fall = ctl_s2_q[3] && !ctl_s3_q[3];
  assign rd_fall  = !ctl_s2_q[1] && ctl_s3_q[1];
  assign wr_rise  = ctl_s2_q[0] && !ctl_s3_q[0];
  assign rd_high  = ctl_s2_q[1];

  // ---------------------------------------------------------------------
  // Address latch
  // ---------------------------------------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic              sel_q;

  // Address and select held from latch strobe fall
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      addr_q <= BYTE_RST;
      sel_q  <= 1'b0;
    end
    else if (ale_fall)
    begin
      addr_q <= ad_s2_q;
      sel_q  <= !ctl_s2_q[2];
    end
  end

  // Decode helpers used by both the read and write paths
  function automatic logic in_buf(input logic [7:0] a,
                                  input logic [7:0] base);
    in_buf = (a[7:BUF_AW] == base[7:BUF_AW]);
  endfunction

  logic host_wr, host_rd;
  assign host_wr = wr_rise && sel_q;
  assign host_rd = rd_fall && sel_q;

  // ---------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------
  logic [7:0] ctrl_q [CTRL_NUM];

  // Only offsets below six are writable control; status and counter
  // offsets fall outside and writes there do nothing
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      for (int i = 0; i < CTRL_NUM; i++)
        ctrl_q[i] <= CTRL_RST;
    end
    else if (host_wr && addr_q < 8'(CTRL_NUM))
      ctrl_q[addr_q[2:0]] <= ad_s2_q;
  end

  assign LINE_MODE_O  = ctrl_q[0];
  assign DL_TX_CTRL_O = ctrl_q[1];
  assign INT_EN_O     = ctrl_q[2];
  assign FEAC_TX_O    = ctrl_q[3];
  assign FEATURE_O    = ctrl_q[4];
  assign HDLC_CTRL_O  = ctrl_q[5];

  // ---------------------------------------------------------------------
  // Link message buffers
  // ---------------------------------------------------------------------
  logic [7:0] tx_buf_q [1 << BUF_AW];
  logic [7:0] rx_buf_q [1 << BUF_AW];

  // Transmit bytes loaded by the host, read by the link side
  always_ff @(posedge CLK_I)
  begin
    if (host_wr && in_buf(addr_q, TRANSMIT_LINK_MESSAGE_BUFFER_OFS))
      tx_buf_q[addr_q[BUF_AW-1:0]] <= ad_s2_q;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      TX_BUF_DATA_O <= BYTE_RST;
    else
      TX_BUF_DATA_O <= tx_buf_q[TX_BUF_ADDR_I];
  end

  // Receive bytes: the link side wins a same-cycle clash, since a
  // received byte cannot be asked to wait
  always_ff @(posedge CLK_I)
  begin
    if (RX_BUF_WE_I)
      rx_buf_q[RX_BUF_ADDR_I] <= RX_BUF_DATA_I;
    else if (host_wr && in_buf(addr_q, RECEIVE_LINK_MESSAGE_BUFFER_OFS))
      rx_buf_q[addr_q[BUF_AW-1:0]] <= ad_s2_q;
  end

  // ---------------------------------------------------------------------
  // Error counters
  // ---------------------------------------------------------------------
  logic [7:0]  par_cnt, ferr_cnt, pth_cnt, febe_cnt;
  logic [3:0]  pdgr_cnt, xdgr_cnt;
  logic [15:0] lcv_cnt;
  logic [6:0]  top_ev;
  logic [6:0]  rd_clr;
  logic        dis_sat;

  // Clear strobes from a host read of each counter address
  assign rd_clr[0] = host_rd && addr_q == PARITY_ERROR_COUNT_OFS;
  assign rd_clr[1] = host_rd && addr_q == DISAGREEMENT_COUNTS_OFS;
  assign rd_clr[2] = host_rd && addr_q == FRAME_ERROR_COUNT_OFS;
  assign rd_clr[3] = host_rd && addr_q == PATH_PARITY_ERROR_COUNT_OFS;
  assign rd_clr[4] = host_rd && addr_q == FAR_END_BLOCK_ERROR_COUNT_OFS;
  assign rd_clr[5] = host_rd && addr_q == CODE_VIOLATION_COUNT_LOW_OFS;
  assign rd_clr[6] = host_rd && addr_q == CODE_VIOLATION_COUNT_HIGH_OFS;
  assign dis_sat   = ctrl_q[4][DIS_SAT_BIT];

  // Each counter is zeroed in the cycle its value is snapshotted for
  // the bus
  fhrp_err_counter #(.W(8)) u_par (
    .clk_i (CLK_I), .rst_n_i (RESET_N_I), .inc_i (PAR_ERR_I),
    .clr_i ({8{rd_clr[0]}}), .roll_i (ctrl_q[2][PAR_BIT]),
    .cnt_o (par_cnt), .top_o (top_ev[0]));
  // Both nibbles cleared by one read
  fhrp_err_counter #(.W(4)) u_pdgr (
    .clk_i (CLK_I), .rst_n_i (RESET_N_I), .inc_i (PAR_DGR_I),
    .clr_i ({4{rd_clr[1]}}), .roll_i (ctrl_q[2][DGR_BIT]),
    .cnt_o (pdgr_cnt), .top_o (top_ev[1]));
  fhrp_err_counter #(.W(4)) u_xdgr (
    .clk_i (CLK_I), .rst_n_i (RESET_N_I), .inc_i (X_DGR_I),
    .clr_i ({4{rd_clr[1]}}), .roll_i (ctrl_q[2][DGR_BIT]),
    .cnt_o (xdgr_cnt), .top_o (top_ev[6]));
  fhrp_err_counter #(.W(8)) u_ferr (
    .clk_i (CLK_I), .rst_n_i (RESET_N_I), .inc_i (FRM_ERR_I),
    .clr_i ({8{rd_clr[2]}}), .roll_i (ctrl_q[2][FERR_BIT] || dis_sat),
    .cnt_o (ferr_cnt), .top_o (top_ev[2]));
  fhrp_err_counter #(.W(8)) u_pth (
    .clk_i (CLK_I), .rst_n_i (RESET_N_I), .inc_i (PTH_ERR_I),
    .clr_i ({8{rd_clr[3]}}), .roll_i (ctrl_q[2][PTH_BIT]),
    .cnt_o (pth_cnt), .top_o (top_ev[3]));
  fhrp_err_counter #(.W(8)) u_febe (
    .clk_i (CLK_I), .rst_n_i (RESET_N_I), .inc_i (FEBE_I),
    .clr_i ({8{rd_clr[4]}}), .roll_i (ctrl_q[2][FEBE_BIT]),
    .cnt_o (febe_cnt), .top_o (top_ev[4]));
  // Bytes clear on their own reads; a carry between the two reads
  // lands in the high byte, hence low byte first
  fhrp_err_counter #(.W(16)) u_lcv (
    .clk_i (CLK_I), .rst_n_i (RESET_N_I), .inc_i (LCV_I),
    .clr_i ({{8{rd_clr[6]}}, {8{rd_clr[5]}}}),
    .roll_i (ctrl_q[2][LCV_BIT] || dis_sat),
    .cnt_o (lcv_cnt), .top_o (top_ev[5]));

  // ---------------------------------------------------------------------
  // Counter interrupt flags
  // ---------------------------------------------------------------------
  logic [5:0] flag_q;
  logic [5:0] flag_set, flag_clr;

  assign flag_set = {top_ev[5:2], top_ev[1] | top_ev[6], top_ev[0]};
  assign flag_clr = {rd_clr[5] | rd_clr[6], rd_clr[4:0]};

  // A new event in the clearing cycle keeps the flag set
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      flag_q <= 6'h00;
    else
      flag_q <= (flag_q & ~flag_clr) | flag_set;
  end

  assign CNT_INT_O = {1'b0, SHADOW_INT_I, flag_q};

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic       rd_act_q;

  // Register selection; unmapped and reserved bits read as zero
  always_comb
  begin
    rd_mux = BYTE_RST;
    if (addr_q < 8'(CTRL_NUM))
      rd_mux = ctrl_q[addr_q[2:0]];
    else if (in_buf(addr_q, TRANSMIT_LINK_MESSAGE_BUFFER_OFS))
      rd_mux = tx_buf_q[addr_q[BUF_AW-1:0]];
    else if (in_buf(addr_q, RECEIVE_LINK_MESSAGE_BUFFER_OFS))
      rd_mux = rx_buf_q[addr_q[BUF_AW-1:0]];
    else
      case (addr_q)
        RECEIVE_ALARM_STATUS_OFS:       rd_mux = ALARM_STATUS_I;
        COUNTER_INTERRUPT_STATUS_OFS:   rd_mux = CNT_INT_O;
        DATA_LINK_INTERRUPT_STATUS_OFS: rd_mux = DL_INT_I & DL_INT_MASK;
        FAR_END_ALARM_RECEIVE_CODE_OFS: rd_mux = FEAC_RX_I;
        DATA_LINK_RECEIVE_STATUS_OFS:   rd_mux = DL_RX_STATUS_I & DL_RX_MASK;
        PART_AND_VERSION_ID_OFS:        rd_mux = PART_VERSION;
        LATCHED_ALARM_SHADOW_OFS:       rd_mux = SHADOW_I & SHADOW_MASK;
        PARITY_ERROR_COUNT_OFS:         rd_mux = par_cnt;
        DISAGREEMENT_COUNTS_OFS:        rd_mux = {pdgr_cnt, xdgr_cnt};
        FRAME_ERROR_COUNT_OFS:          rd_mux = ferr_cnt;
        PATH_PARITY_ERROR_COUNT_OFS:    rd_mux = pth_cnt;
        FAR_END_BLOCK_ERROR_COUNT_OFS:  rd_mux = febe_cnt;
        CODE_VIOLATION_COUNT_LOW_OFS:   rd_mux = lcv_cnt[7:0];
        CODE_VIOLATION_COUNT_HIGH_OFS:  rd_mux = lcv_cnt[15:8];
        default:                        rd_mux = BYTE_RST;
      endcase
  end

  // Snapshot once at read start so the byte stays steady while the
  // counter behind it keeps running
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      rdata_q <= BYTE_RST;
    else if (host_rd)
      rdata_q <= rd_mux;
  end

  // Bus driven from read start until the synchronised strobe returns
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      rd_act_q <= 1'b0;
    else if (host_rd)
      rd_act_q <= 1'b1;
    else if (rd_high)
      rd_act_q <= 1'b0;
  end

  assign AD_O    = rdata_q;
  assign AD_OE_O = rd_act_q;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_addr_capture: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    ale_fall |=> addr_q == $past(ad_s2_q))
    else $error("address not captured at latch fall");

  a_ctrl_readback: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    host_rd
    && addr_q == FEATURE_CONTROL_OFS
    |=> AD_OE_O && AD_O == FEATURE_O)
    else $error("control readback differs");

  a_write_value: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    host_wr && addr_q == INTERRUPT_ENABLE_CONTROL_OFS
    |=> INT_EN_O == $past(ad_s2_q))
    else $error("written value not taken at strobe rise");

  a_status_ro: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    host_wr && addr_q >= RECEIVE_ALARM_STATUS_OFS
    && addr_q <= CODE_VIOLATION_COUNT_HIGH_OFS
    |=> $stable({LINE_MODE_O, DL_TX_CTRL_O, INT_EN_O, FEAC_TX_O,
                 FEATURE_O, HDLC_CTRL_O}))
    else $error("write to read-only address changed control");

  a_par_clear: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    rd_clr[0] |=> par_cnt == 8'($past(PAR_ERR_I))
    && AD_O == $past(par_cnt))
    else $error("parity count lost or doubled across read");

  a_dgr_clear: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    rd_clr[1] |=> pdgr_cnt <= 4'h1 && xdgr_cnt <= 4'h1)
    else $error("disagreement nibbles not both cleared");

  a_flag_clear: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    rd_clr[3] && !top_ev[3] |=> !flag_q[PTH_BIT])
    else $error("counter flag not cleared by read");

  a_txbuf_store: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    host_wr && in_buf(addr_q, TRANSMIT_LINK_MESSAGE_BUFFER_OFS)
    |=> tx_buf_q[$past(addr_q[BUF_AW-1:0])] == $past(ad_s2_q))
    else $error("transmit buffer byte not stored");

  a_rxbuf_read: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    host_rd && in_buf(addr_q, RECEIVE_LINK_MESSAGE_BUFFER_OFS)
    |=> AD_OE_O && AD_O == $past(rx_buf_q[addr_q[BUF_AW-1:0]]))
    else $error("receive buffer byte not returned");

endmodule

// ---- sim/fhrp_host_model.sv ----
// Host processor model: multiplexed bus cycles on the register port.
// Assumes CLK_I is the receive clock; the bench resolves the bus.
`timescale 1ns/10ps
module fhrp_host_model (
  input  wire logic       clk_i,  // Receive clock
  input  wire logic [7:0] bus_i,  // Resolved bus
  output logic            ale_o,  // Address latch
  output logic            cs_n_o, // Chip select
  output logic            rd_n_o, // Read strobe
  output logic            wr_n_o, // Write strobe
  output logic [7:0]      ad_o,   // Host value
  output logic            oe_o    // Host drives bus
);
  initial {ale_o, cs_n_o, rd_n_o, wr_n_o, ad_o, oe_o} = 13'h0e01;
  // One bus cycle; every phase lasts whole clocks, so slow sync still
  // sees each level
  task automatic cyc(input logic [7:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i) {ale_o, cs_n_o, ad_o, oe_o} = {2'b10, a, 1'b1};
    repeat (2) @(negedge clk_i);
    ale_o = 1'b0;
    repeat (3) @(negedge clk_i);
    ad_o = d;
    oe_o = w;
    if (w) wr_n_o = 1'b0; else rd_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    q = bus_i;
    {rd_n_o, wr_n_o} = 2'b11;
    repeat (3) @(negedge clk_i);
    {cs_n_o, oe_o} = 2'b10;
    repeat (3) @(negedge clk_i);
  endtask
endmodule

// ---- sim/framer_host_register_port_tb_top.sv ----
// Bench: register port cycles through the host model, checked values.
// Assumes the port answers within five clocks of a read strobe.
`timescale 1ns/10ps
module framer_host_register_port_tb_top;
  logic       clk, rst_n, ale, cs_n, rd_n, wr_n, hoe, ad_oe, rx_we, sh;
  logic [7:0] had, bus, ad_o, rxd, txd, q, alm, cint;
  wire  [47:0] ctl_pins;
  logic [6:0] err;
  logic [2:0] txa, rxa;
  int         num_errors, tests_run;
  logic [7:0] sa [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
  logic [7:0] se [7] = '{8'ha5, 8'h40, 8'h0f, 8'h3c, 8'h3f, 8'h69, 8'h3f};
  // Released bus shows the inverse of the last host value
  assign bus = ad_oe ? ad_o : (hoe ? had : ~had);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  fhrp_host_port #(.PART_VERSION(8'h69)) fhrp_host_port_inst ( // Arbitrary
    .CLK_I(clk), .RESET_N_I(rst_n), .ALE_I(ale), .CS_N_I(cs_n),
    .RD_N_I(rd_n), .WR_N_I(wr_n), .AD_I(bus), .AD_O(ad_o), .AD_OE_O(ad_oe),
    .LINE_MODE_O(ctl_pins[7:0]), .DL_TX_CTRL_O(ctl_pins[15:8]),
    .INT_EN_O(ctl_pins[23:16]), .FEAC_TX_O(ctl_pins[31:24]),
    .FEATURE_O(ctl_pins[39:32]), .HDLC_CTRL_O(ctl_pins[47:40]),
    .ALARM_STATUS_I(alm),
    .DL_INT_I(8'hff), .FEAC_RX_I(8'h3c), .DL_RX_STATUS_I(8'hff),
    .SHADOW_I(8'hff), .SHADOW_INT_I(sh), .PAR_ERR_I(err[0]),
    .PAR_DGR_I(err[1]), .X_DGR_I(err[2]), .FRM_ERR_I(err[3]),
    .PTH_ERR_I(err[4]), .FEBE_I(err[5]), .LCV_I(err[6]),
    .TX_BUF_ADDR_I(txa), .TX_BUF_DATA_O(txd), .RX_BUF_WE_I(rx_we),
    .RX_BUF_ADDR_I(rxa), .RX_BUF_DATA_I(rxd), .CNT_INT_O(cint));
  fhrp_host_model fhrp_host_model_inst (
    .clk_i(clk), .bus_i(bus), .ale_o(ale), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .ad_o(had), .oe_o(hoe));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    fhrp_host_model_inst.cyc(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, e);
    fhrp_host_model_inst.cyc(a, 1'b0, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // One-cycle error pulses with a gap, one count each
  task automatic pulse(input int b, n);
    repeat (n)
    begin
      @(negedge clk) err[b] = 1'b1;
      @(negedge clk) err[b] = 1'b0;
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog: the run needs about 11 us
  initial
  begin
    #200us;
    num_errors++;
    complete_run();
  end
  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial
  begin
    {rst_n, rx_we, sh, err, txa, rxa, rxd} = '0;
    num_errors = 0;
    tests_run = 0;
    alm = 8'ha5;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    sh = 1'b1;
    for (int i = 0; i < 6; i++)
      wr(i[7:0], {i[3:0], ~i[3:0]});
    for (int i = 0; i < 6; i++)
      rd(i[7:0], {i[3:0], ~i[3:0]});
    for (int i = 0; i < 6; i++)
      chk("ctrl_pin", {i[3:0], ~i[3:0]}, ctl_pins[i*8 +: 8]);
    for (int i = 0; i < 8; i++)
      wr(8'h30 + i[7:0], 8'hc0 + i[7:0]);
    for (int i = 0; i < 8; i++)
      rd(8'h30 + i[7:0], 8'hc0 + i[7:0]);
    @(negedge clk) txa = 3'd5;
    repeat (2) @(negedge clk);
    chk("tx_link", 8'hc5, txd);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk) {rx_we, rxa, rxd} = {1'b1, i[2:0], 8'h90 + i[7:0]};
      @(negedge clk) rx_we = 1'b0;
      rd(8'h40 + i[7:0], 8'h90 + i[7:0]);
    end
    wr(8'h10, 8'h00);
    foreach (sa[i])
      rd(sa[i], se[i]);
    alm = 8'h5a;
    rd(8'h10, 8'h5a);
    pulse(0, 3);
    wr(8'h20, 8'h77);
    rd(8'h20, 8'h03);
    rd(8'h20, 8'h00);
    pulse(0, 2);
    // Error lands on the very edge that snapshots and clears the count
    fork
      rd(8'h20, 8'h02);
      begin
        repeat (8) @(negedge clk);
        err[0] = 1'b1;
        @(negedge clk) err[0] = 1'b0;
      end
    join
    rd(8'h20, 8'h01);
    pulse(1, 2);
    pulse(2, 1);
    rd(8'h21, 8'h21);
    rd(8'h21, 8'h00);
    // Sixteenth mismatch hits the saturated nibble and raises its flag
    pulse(1, 16);
    rd(8'h11, 8'h42);
    chk("cnt_int_pin", 8'h42, cint);
    rd(8'h21, 8'hf0);
    rd(8'h11, 8'h40);
    chk("cnt_int_pin", 8'h40, cint);
    for (int i = 3; i < 6; i++)
    begin
      pulse(i, i);
      rd(8'h1f + i[7:0], i[7:0]);
    end
    pulse(6, 5);
    rd(8'h25, 8'h05);
    rd(8'h26, 8'h00);
    rd(8'h50, 8'h00);
    complete_run();
  end
endmodule
